// ---- tb/pps_power_model.sv ----
`timescale 1ns/1ns
// power companion and host: owns reset, fast park and projector-on
module pps_power_model (
    input wire logic i_clock,
    input wire logic i_host_line, // resolved interrupt line
    output logic o_controller_reset_n,
    output logic o_fast_park_request_n,
    output logic o_projector_on_request
);
    // parked and in reset at power-on
    initial
    begin
        o_controller_reset_n = 1'b0;
        o_fast_park_request_n = 1'b0;
        o_projector_on_request = 1'b0;
    end
    // inputs move a fixed 1 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : step
    // hold varies so release comes promptly or slowly
    task automatic power_up(input int hold);
        o_projector_on_request = 1'b1;
        o_fast_park_request_n = 1'b1;
        step(hold);
        // the companion's own ready comes long after boot; the sequencer never waits on it
        o_controller_reset_n = 1'b1;
    endtask : power_up
    // only once the line is low; bus traffic already ended
    task automatic power_off();
        if (i_host_line === 1'b0)
        begin
            o_projector_on_request = 1'b0;
        end
    endtask : power_off
    task automatic fault();
        o_fast_park_request_n = 1'b0;
    endtask : fault
    // called only after parking ends; supplies held until then
    task automatic assert_reset();
        o_controller_reset_n = 1'b0;
        o_projector_on_request = 1'b0;
    endtask : assert_reset
endmodule : pps_power_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    import pps_pkg::*;
    localparam int B = 20; // shortened counts
    localparam int S = 10;
    localparam int N = 8;
    localparam int F = 4;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic rst_n, park_n, on_req, irq, irq_oe_n, cmd_rdy, setup, disp, busy, done, sel0, sel1, arr_n;
    logic host_line; // pulled up when undriven
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n, m, e; // edge counts, scenario index, expected value
    int exp_q[$]; // bench model: expected results, pushed at stimulus, popped at result
    assign host_line = irq_oe_n ? 1'b1 : irq;
    always #5 i_clock = ~i_clock;
    pps_sequencer #(.P_BOOT_CYC(B), .P_SETUP_CYC(S), .P_NPARK_CYC(N), .P_FPARK_CYC(F)) pps_sequencer_i (
        .i_clock(i_clock), .i_rst(i_rst), .i_controller_reset_n(rst_n), .i_fast_park_request_n(park_n),
        .i_projector_on_request(on_req), .o_host_irq(irq), .o_host_irq_oe_n(irq_oe_n), .o_cmd_ready(cmd_rdy),
        .o_companion_setup(setup), .o_display_active(disp), .o_park_busy(busy), .o_park_done(done),
        .o_illumination_select_0(sel0), .o_illumination_select_1(sel1), .o_array_reset_enable_n(arr_n));
    pps_power_model pps_power_model_i (.i_clock(i_clock), .i_host_line(host_line),
        .o_controller_reset_n(rst_n), .o_fast_park_request_n(park_n), .o_projector_on_request(on_req));
    // hang guard; whole run needs a few hundred cycles
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test
    // value must lie in lo..hi; unknown never matches
    task automatic check(input string what, input int lo, input int hi, input logic [31:0] got);
        samples_checked++;
        if ($isunknown(got) || got < lo || got > hi)
        begin
            fail_count++;
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : check
    // bounded wait for line low or parked, counting edges
    task automatic wait_for(input bit on_done, output int k);
        k = 0;
        do
        begin
            @(posedge i_clock);
            #1;
            k++;
        end
        while (k < 200 && (on_done ? done !== 1'b1 : host_line !== 1'b0));
    endtask : wait_for
    // idle state: line released, lamp and array enables low
    task automatic check_quiet();
        check("line", 1, 1, host_line);
        check("sel0", 0, 0, sel0);
        check("sel1", 0, 0, sel1);
        check("arr_n", 0, 0, arr_n);
    endtask : check_quiet
    initial
    begin
        void'($urandom(32'hA5D3));
        pps_power_model_i.step(5);
        check_quiet();
        i_rst = 1'b0;
        // 0 normal park, 1 fast from ready, 2 fast in normal park, 3 fast in boot, 4 fast in setup
        for (m = 0; m < 5; m++)
        begin
            pps_power_model_i.power_up(1 + $urandom % 6);
            if (m >= 3)
            begin
                pps_power_model_i.step(m == 3 ? 3 + $urandom % (B - 2) : B + 3 + $urandom % (S - 1));
                check("oe_n", 0, 0, irq_oe_n);
                check("irq", 1, 1, irq);
                check("setup", m - 3, m - 3, setup);
                pps_power_model_i.fault();
            end
            else
            begin
                exp_q.push_back(B + S + 3); // model: sync edge, start edge, boot, setup, one edge to the line
                pps_power_model_i.step(B + 4);
                check("setup", 1, 1, setup);
                check("early", 0, 0, cmd_rdy);
                wait_for(1'b0, n);
                e = exp_q.pop_front();
                check("boot", e - 1, e + 1, B + 4 + n);
                check("cmd", 1, 1, cmd_rdy);
                check("disp", 1, 1, disp);
                check("sel0", 1, 1, sel0);
                check("arr_n", 1, 1, arr_n);
                if (m != 1)
                    pps_power_model_i.power_off();
                if (m == 2)
                begin
                    pps_power_model_i.step(3);
                    check("busy", 1, 1, busy);
                end
                if (m != 0)
                    pps_power_model_i.fault();
            end
            exp_q.push_back((m == 0 ? N : F) + 2); // model: edge to start, park cycles, edge to done
            wait_for(1'b1, n);
            e = exp_q.pop_front();
            if (m == 0)
                check("npark", e - 1, e + 2, n);
            else
                check("fpark", e - 1, e + 2, n);
            check("arr_n", 0, 0, arr_n);
            check("cmd", 0, 0, cmd_rdy);
            pps_power_model_i.assert_reset();
            pps_power_model_i.step(3);
            check_quiet();
        end
        stop_test();
    end
endmodule : testbench

// ---- verilog/pps_pkg.sv ----
package pps_pkg;
    // clock rate in kHz; 100 MHz clock, 10 ns period
    localparam int CLK_KHZ = 100000;
    // phase times in their natural units
    localparam int BOOT_MS = 100;
    localparam int SETUP_US = 2750;
    localparam int NORMAL_PARK_MS = 20;
    localparam int FAST_PARK_US = 32;
    // derived cycle counts; microsecond times use the rate rounded down to MHz
    localparam int BOOT_CYC = BOOT_MS * CLK_KHZ;
    localparam int SETUP_CYC = SETUP_US * (CLK_KHZ / 1000);
    localparam int NORMAL_PARK_CYC = NORMAL_PARK_MS * CLK_KHZ;
    localparam int FAST_PARK_CYC = FAST_PARK_US * (CLK_KHZ / 1000);
    // timer width covers the longest count
    localparam int TMR_W = 32;
    // sequencer states
    typedef enum logic [2:0] {
        PPS_OFF,
        PPS_BOOT,
        PPS_SETUP,
        PPS_READY,
        PPS_NPARK,
        PPS_FPARK,
        PPS_PARKED
    } pps_state_type;
endpackage : pps_pkg

// ---- verilog/pps_sequencer.sv ----
`timescale 1ns/1ns
// Contract
// - init after reset release; irq low; then commands
// - boot takes about 100 ms
// - 2.75 ms companion setup before commands
// - normal park completes within 20 ms
// - reset only after park; irq released
// - fast park request starts fast park immediately
// - projector-on high runs, low powers down
// - reset forces illumination and array enable low
module pps_sequencer #(
    parameter int unsigned P_BOOT_CYC = pps_pkg::BOOT_CYC, // shorten in simulation
    parameter int unsigned P_SETUP_CYC = pps_pkg::SETUP_CYC,
    parameter int unsigned P_NPARK_CYC = pps_pkg::NORMAL_PARK_CYC,
    parameter int unsigned P_FPARK_CYC = pps_pkg::FAST_PARK_CYC
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_controller_reset_n, // held low by the power monitor
    input wire logic i_fast_park_request_n, // low requests a fast park
    input wire logic i_projector_on_request, // high runs the projector
    output logic o_host_irq, // drive value of the host interrupt line
    output logic o_host_irq_oe_n, // low while the line is driven
    output logic o_cmd_ready, // serial commands may be accepted
    output logic o_companion_setup, // writing the companion chip
    output logic o_display_active, // image display running
    output logic o_park_busy, // a park of the array is under way
    output logic o_park_done, // array parked, reset may now be asserted
    output logic o_illumination_select_0,
    output logic o_illumination_select_1,
    output logic o_array_reset_enable_n
);
    import pps_pkg::*;

    pps_state_type state_q; // sequencer state
    logic [TMR_W-1:0] tmr_q; // down counter for the current phase
    logic rst_n_q; // registered controller reset, one sync stage is enough here
    logic in_reset; // controller held in reset

    // the controller reset is taken as a level; pins are synchronous to i_clock
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            rst_n_q <= 1'b0;
        else
            rst_n_q <= i_controller_reset_n;
    end

    // asserted at once from the pin, released one clock later
    assign in_reset = !i_controller_reset_n || !rst_n_q;

    // main sequencer; reset restarts it from the top on every release
    always_ff @(posedge i_clock)
    begin
        if (i_rst || in_reset)
        begin
            state_q <= PPS_OFF;
            tmr_q <= '0;
        end
        else
        begin
            case (state_q)
                PPS_OFF:
                begin
                    // boot starts only with the projector requested and no park pending
                    if (i_projector_on_request && i_fast_park_request_n)
                    begin
                        state_q <= PPS_BOOT;
                        tmr_q <= TMR_W'(P_BOOT_CYC - 1);
                    end
                end
                PPS_BOOT:
                begin
                    if (!i_fast_park_request_n)
                    begin
                        state_q <= PPS_FPARK;
                        tmr_q <= TMR_W'(P_FPARK_CYC - 1);
                    end
                    else if (tmr_q == '0)
                    begin
                        state_q <= PPS_SETUP;
                        tmr_q <= TMR_W'(P_SETUP_CYC - 1);
                    end
                    else
                        tmr_q <= tmr_q - 1'b1;
                end
                PPS_SETUP:
                begin
                    if (!i_fast_park_request_n)
                    begin
                        state_q <= PPS_FPARK;
                        tmr_q <= TMR_W'(P_FPARK_CYC - 1);
                    end
                    else if (tmr_q == '0)
                        state_q <= PPS_READY;
                    else
                        tmr_q <= tmr_q - 1'b1;
                end
                PPS_READY:
                begin
                    if (!i_fast_park_request_n)
                    begin
                        state_q <= PPS_FPARK;
                        tmr_q <= TMR_W'(P_FPARK_CYC - 1);
                    end
                    else if (!i_projector_on_request)
                    begin
                        // host has finished bus traffic before lowering the request
                        state_q <= PPS_NPARK;
                        tmr_q <= TMR_W'(P_NPARK_CYC - 1);
                    end
                end
                PPS_NPARK:
                begin
                    // a fast request overrides the slower normal park
                    if (!i_fast_park_request_n)
                    begin
                        state_q <= PPS_FPARK;
                        tmr_q <= TMR_W'(P_FPARK_CYC - 1);
                    end
                    else if (tmr_q == '0)
                        state_q <= PPS_PARKED;
                    else
                        tmr_q <= tmr_q - 1'b1;
                end
                PPS_FPARK:
                begin
                    if (tmr_q == '0)
                        state_q <= PPS_PARKED;
                    else
                        tmr_q <= tmr_q - 1'b1;
                end
                default:
                begin
                    // parked: wait for the monitor to assert reset
                    state_q <= PPS_PARKED;
                end
            endcase
        end
    end

    // interrupt line: released in reset (pull-up), driven high during init, low when done
    always_ff @(posedge i_clock)
    begin
        if (i_rst || in_reset)
        begin
            o_host_irq <= 1'b1;
            o_host_irq_oe_n <= 1'b1;
        end
        else
        begin
            o_host_irq_oe_n <= 1'b0;
            // low from init done, or from the start of a fast park in boot or setup, until reset; stays low through parking
            o_host_irq <= !(state_q == PPS_READY || state_q == PPS_NPARK || state_q == PPS_FPARK
                || state_q == PPS_PARKED);
        end
    end

    // status and array-facing outputs, all registered
    always_ff @(posedge i_clock)
    begin
        if (i_rst || in_reset)
        begin
            o_cmd_ready <= 1'b0;
            o_companion_setup <= 1'b0;
            o_display_active <= 1'b0;
            o_park_busy <= 1'b0;
            o_park_done <= 1'b0;
            o_illumination_select_0 <= 1'b0;
            o_illumination_select_1 <= 1'b0;
            o_array_reset_enable_n <= 1'b0;
        end
        else
        begin
            o_cmd_ready <= (state_q == PPS_READY);
            o_companion_setup <= (state_q == PPS_SETUP);
            o_display_active <= (state_q == PPS_READY);
            o_park_busy <= (state_q == PPS_NPARK || state_q == PPS_FPARK);
            o_park_done <= (state_q == PPS_PARKED);
            // illumination is selected only while displaying; parked array disabled
            o_illumination_select_0 <= (state_q == PPS_READY);
            o_illumination_select_1 <= 1'b0;
            o_array_reset_enable_n <= (state_q != PPS_OFF && state_q != PPS_PARKED);
        end
    end

    // park phase length counter for checks
    logic [TMR_W-1:0] park_len_q;
    always_ff @(posedge i_clock)
    begin
        if (i_rst || in_reset || !(state_q == PPS_NPARK || state_q == PPS_FPARK))
            park_len_q <= '0;
        else
            park_len_q <= park_len_q + 1'b1;
    end

    chk_reset_outputs_low: assert property (@(posedge i_clock) disable iff (i_rst)
        !rst_n_q |=> (!o_illumination_select_0 && !o_array_reset_enable_n && o_host_irq_oe_n))
        else $error("outputs not forced during reset");
    chk_irq_low_ready: assert property (@(posedge i_clock) disable iff (i_rst || in_reset)
        (state_q == PPS_READY) |=> (!o_host_irq && !o_host_irq_oe_n))
        else $error("irq not low after init");
    chk_cmd_after_setup: assert property (@(posedge i_clock) disable iff (i_rst || in_reset)
        $rose(o_cmd_ready) |-> $past(state_q, 2) == PPS_SETUP)
        else $error("commands ready without setup");
    chk_fast_park_start: assert property (@(posedge i_clock) disable iff (i_rst || in_reset)
        (!i_fast_park_request_n && state_q inside {PPS_BOOT, PPS_SETUP, PPS_READY, PPS_NPARK})
        |=> state_q == PPS_FPARK)
        else $error("fast park not started");
    chk_normal_park_bound: assert property (@(posedge i_clock) disable iff (i_rst || in_reset)
        (state_q == PPS_NPARK) |-> park_len_q < TMR_W'(P_NPARK_CYC))
        else $error("normal park too long");
    chk_fast_park_bound: assert property (@(posedge i_clock) disable iff (i_rst || in_reset)
        (state_q == PPS_FPARK) |-> park_len_q < TMR_W'(P_NPARK_CYC + P_FPARK_CYC))
        else $error("fast park too long");
    chk_off_until_on: assert property (@(posedge i_clock) disable iff (i_rst || in_reset)
        (state_q == PPS_OFF && !i_projector_on_request) |=> state_q == PPS_OFF)
        else $error("boot without request");
    chk_release_restart: assert property (@(posedge i_clock) disable iff (i_rst)
        in_reset |=> state_q == PPS_OFF)
        else $error("reset did not restart");

    cov_boot_done: cover property (@(posedge i_clock) disable iff (i_rst) $rose(o_cmd_ready));
    cov_normal_park: cover property (@(posedge i_clock) disable iff (i_rst)
        state_q == PPS_NPARK ##1 state_q == PPS_PARKED);
    cov_fast_over_normal: cover property (@(posedge i_clock) disable iff (i_rst)
        state_q == PPS_NPARK ##1 state_q == PPS_FPARK);
    cov_fast_park: cover property (@(posedge i_clock) disable iff (i_rst)
        state_q == PPS_FPARK ##1 state_q == PPS_PARKED);
endmodule : pps_sequencer
